// >>> src/cipl_cfg.svh
// Constants of the core interrupt priority logic: offsets, fields, timing.
// Assumes inclusion by bare name from the package, the design file and the bench.
`ifndef CIPL_CFG_SVH
`define CIPL_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CIPL_ADDR_CTRL    12'h000
`define CIPL_ADDR_FLAGS   12'h004
`define CIPL_ADDR_STATUS  12'h008

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CIPL_CTRL_GEN     0
`define CIPL_CTRL_CONV_EN 1
`define CIPL_CTRL_PEN_LSB 8

// ----------------------------------------------------------------
// Timing, in CPU cycles and core clocks
// ----------------------------------------------------------------
`define CIPL_CPU_CYCLE_CLKS 13
`define CIPL_RESP_MIN_CPU   6
`define CIPL_RESP_MAX_CPU   11
`define CIPL_RESP_MIN_CLKS  (`CIPL_RESP_MIN_CPU * `CIPL_CPU_CYCLE_CLKS)

// ----------------------------------------------------------------
// Stack, vectors, port interrupt configuration {dir, option, value}
// ----------------------------------------------------------------
`define CIPL_STACK_DEPTH  6
`define CIPL_PC_W         12
`define CIPL_VEC_BASE     12'hFF0
`define CIPL_EXT_CFG      3'h2
`define CIPL_CNT_W        7

`endif

// >>> src/cipl_pkg.sv
// Types of the core interrupt priority logic.
// Assumes the constants header sits beside it.
`include "cipl_cfg.svh"

package cipl_pkg;
  typedef enum logic [1:0] {
    CIPL_MODE_NORMAL,
    CIPL_MODE_IRQ,
    CIPL_MODE_NMI
  } cipl_mode_t;

  typedef enum logic {
    CIPL_ST_IDLE,
    CIPL_ST_ENTRY
  } cipl_state_t;
endpackage : cipl_pkg

// >>> src/cipl_ctrl.sv
// Interrupt arbitration, entry and return sequencing for a small core.
// Assumes an APB master on mclk, a core sequencer that pulses its events
// on mclk and asynchronous pins for the non-maskable input and the port.
//
// How it works
// - Reset pre-empts any running service
// - Non-maskable pre-empts peripherals, never nests itself
// - No peripheral interrupt inside a peripheral service
// - Fixed priority, vector 0 highest, 4 lowest
// - Any request wakes wait; chosen ones stop
// - Non-maskable falling edge ignores global enable
// - Non-maskable latch cleared at service start
// - Peripheral needs global and own enable
// - Peripheral requests go to vectors 3, 4
// - Peripheral flags stay until software clears
// - Entry switches to interrupt or non-maskable flags
// - Entry pushes program counter onto stack
// - Maskable lines blocked during any service
// - Entry clears source latch, then loads vector
// - Return pops address and resumes routine
// - Option-clear load: enter, keep main flags
// - Response takes six to eleven CPU cycles
// - Port event needs pin configuration and enable
// - Conversion done wakes wait, not stop
// - Reset starts in non-maskable mode and flags
// - Return restores previous flags, values kept
// - Six 12-bit levels, push drops deepest
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`include "cipl_cfg.svh"

module cipl_ctrl #(
  parameter int                  PIN_N          = 4,
  parameter int                  PERIPH_N       = 2,
  parameter int                  STACK_N        = `CIPL_STACK_DEPTH,
  parameter logic [PIN_N-1:0]    PIN_VEC2_MASK  = '0,
  parameter logic [PERIPH_N-1:0] VEC4_MASK      = '0,
  parameter logic [PERIPH_N-1:0] STOP_WAKE_MASK = '0
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  nmi_pin_b,
  input  wire logic [PIN_N-1:0]      port_pin,
  input  wire logic [PIN_N-1:0]      port_dir,
  input  wire logic [PIN_N-1:0]      pin_value_bits,
  input  wire logic [PIN_N-1:0]      port_opt,
  input  wire logic [PERIPH_N-1:0]   periph_evt,
  input  wire logic                  conv_done,
  input  wire logic [11:0]           core_pc,
  input  wire logic                  core_instr_end,
  input  wire logic                  core_call,
  input  wire logic                  core_ret,
  input  wire logic                  core_return_from_isr,
  input  wire logic                  core_ldi_ior_clr,
  input  wire logic                  core_wait,
  input  wire logic                  core_stop,
  input  wire logic                  flag_we,
  input  wire logic                  carry_in,
  input  wire logic                  zero_in,
  output logic                       pc_load,
  output logic      [11:0]           pc_addr,
  output logic      [1:0]            irq_mode,
  output logic      [1:0]            flag_sel,
  output logic                       carry_out,
  output logic                       zero_out,
  output logic                       wake
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (PIN_N < 1 || PERIPH_N < 1 || PERIPH_N > 8 || STACK_N < 1 || STACK_N > 7 ||
        `CIPL_RESP_MIN_CLKS < 2 || `CIPL_RESP_MIN_CLKS > 127) begin : g_bad
      $error("cipl_ctrl: parameter out of range");
    end
  endgenerate

  localparam logic [`CIPL_CNT_W-1:0] RESP_LOAD = `CIPL_CNT_W'(`CIPL_RESP_MIN_CLKS - 2);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cipl_pkg::cipl_mode_t  mode_reg, mode_next, sel_reg, sel_next;
  cipl_pkg::cipl_mode_t  nmi_prev_mode_reg, nmi_prev_sel_reg, irq_prev_sel_reg;
  cipl_pkg::cipl_state_t state_reg;
  logic [`CIPL_CNT_W-1:0] cnt_reg;
  logic [2:0]             vec_reg;
  logic                   gen_reg, conv_en_reg;
  logic [PERIPH_N-1:0]    pen_reg, pflag_reg, pflag_clr;
  logic                   nmi_latch_reg;
  logic [1:0]             ext_latch_reg, ext_set;
  logic [11:0]            stack_reg [STACK_N];
  logic [2:0]             depth_reg;
  logic [1:0]             cz_reg [3];
  logic                   pc_load_reg, wake_reg, carry_reg, zero_reg;
  logic [11:0]            pc_addr_reg;
  logic [31:0]            prdata_reg;
  logic                   pready_reg, pslverr_reg;

  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, second and third must agree
  // ----------------------------------------------------------------
  logic [PIN_N:0] raw_pins, s1_reg, s2_reg, s3_reg, filt_reg, fall;
  assign raw_pins = {port_pin, nmi_pin_b};

  genvar gi;
  generate
    for (gi = 0; gi <= PIN_N; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          s1_reg[gi]   <= 1'b1;
          s2_reg[gi]   <= 1'b1;
          s3_reg[gi]   <= 1'b1;
          filt_reg[gi] <= 1'b1;
        end else begin
          s1_reg[gi] <= raw_pins[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
      assign fall[gi] = filt_reg[gi] & (s2_reg[gi] == s3_reg[gi]) & ~s3_reg[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Requests and arbitration
  // ----------------------------------------------------------------
  logic       wr_hit, setup;
  logic [4:0] req;
  logic       maskable_ok, accept, stop_src, any_src;
  logic [2:0] sel_vec;

  assign setup  = psel & ~penable;
  assign wr_hit = psel & penable & pready_reg & pwrite;

  always_comb begin
    ext_set = 2'h0;
    for (int i = 0; i < PIN_N; i++) begin
      if (fall[i+1] && gen_reg && {port_dir[i], port_opt[i], pin_value_bits[i]} == `CIPL_EXT_CFG) begin
        ext_set[PIN_VEC2_MASK[i]] = 1'b1;
      end
    end
  end

  assign req[0] = nmi_latch_reg;
  assign req[1] = ext_latch_reg[0];
  assign req[2] = ext_latch_reg[1];
  assign req[3] = |(pflag_reg & pen_reg & ~VEC4_MASK);
  assign req[4] = |(pflag_reg & pen_reg & VEC4_MASK) | (conv_done & conv_en_reg);

  assign maskable_ok = gen_reg & (mode_reg == cipl_pkg::CIPL_MODE_NORMAL);

  always_comb begin
    sel_vec = 3'h0;
    if (req[0] && mode_reg != cipl_pkg::CIPL_MODE_NMI) begin
      sel_vec = 3'h0;
    end else if (maskable_ok && req[1]) begin
      sel_vec = 3'h1;
    end else if (maskable_ok && req[2]) begin
      sel_vec = 3'h2;
    end else if (maskable_ok && req[3]) begin
      sel_vec = 3'h3;
    end else begin
      sel_vec = 3'h4;
    end
  end

  assign accept = (state_reg == cipl_pkg::CIPL_ST_IDLE) & core_instr_end &
                  ((req[0] & (mode_reg != cipl_pkg::CIPL_MODE_NMI)) |
                   (maskable_ok & |req[4:1]));

  // ----------------------------------------------------------------
  // Latches and flags: a set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  assign pflag_clr = (wr_hit && paddr == `CIPL_ADDR_FLAGS) ? pwdata[PERIPH_N-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      nmi_latch_reg <= 1'b0;
      ext_latch_reg <= 2'h0;
    end else begin
      nmi_latch_reg <= (nmi_latch_reg & ~(accept && sel_vec == 3'h0)) | fall[0];
      ext_latch_reg <= (ext_latch_reg & ~{accept && sel_vec == 3'h2,
                                          accept && sel_vec == 3'h1}) | ext_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pflag_reg <= '0;
    end else begin
      pflag_reg <= (pflag_reg & ~pflag_clr) | periph_evt;
    end
  end

  // ----------------------------------------------------------------
  // Mode and flag context
  // ----------------------------------------------------------------
  logic return_from_isr_ok;
  assign return_from_isr_ok = core_return_from_isr & (state_reg == cipl_pkg::CIPL_ST_IDLE) & ~accept;

  always_comb begin
    mode_next = mode_reg;
    sel_next  = sel_reg;
    if (accept && sel_vec == 3'h0) begin
      mode_next = cipl_pkg::CIPL_MODE_NMI;
      sel_next  = cipl_pkg::CIPL_MODE_NMI;
    end else if (accept) begin
      mode_next = cipl_pkg::CIPL_MODE_IRQ;
      if (!core_ldi_ior_clr) begin
        sel_next = cipl_pkg::CIPL_MODE_IRQ;
      end
    end else if (return_from_isr_ok && mode_reg == cipl_pkg::CIPL_MODE_NMI) begin
      mode_next = nmi_prev_mode_reg;
      sel_next  = nmi_prev_sel_reg;
    end else if (return_from_isr_ok && mode_reg == cipl_pkg::CIPL_MODE_IRQ) begin
      mode_next = cipl_pkg::CIPL_MODE_NORMAL;
      sel_next  = irq_prev_sel_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_reg          <= cipl_pkg::CIPL_MODE_NMI;
      sel_reg           <= cipl_pkg::CIPL_MODE_NMI;
      nmi_prev_mode_reg <= cipl_pkg::CIPL_MODE_NORMAL;
      nmi_prev_sel_reg  <= cipl_pkg::CIPL_MODE_NORMAL;
      irq_prev_sel_reg  <= cipl_pkg::CIPL_MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
      sel_reg  <= sel_next;
      if (accept && sel_vec == 3'h0) begin
        nmi_prev_mode_reg <= mode_reg;
        nmi_prev_sel_reg  <= sel_reg;
      end else if (accept) begin
        irq_prev_sel_reg <= sel_reg;
      end
    end
  end

  // Flag values survive context switches
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) begin
        cz_reg[i] <= 2'h0;
      end
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else begin
      if (flag_we) begin
        cz_reg[sel_reg] <= {carry_in, zero_in};
      end
      if (flag_we && sel_next == sel_reg) begin
        {carry_reg, zero_reg} <= {carry_in, zero_in};
      end else begin
        {carry_reg, zero_reg} <= cz_reg[sel_next];
      end
    end
  end

  // ----------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------
  logic push, pop;
  assign push = accept | (core_call & ~accept);
  assign pop  = (return_from_isr_ok | (core_ret & ~accept)) & (depth_reg != 3'h0);

  generate
    for (gi = 0; gi < STACK_N; gi++) begin : g_stack
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          stack_reg[gi] <= 12'h000;
        end else if (push) begin
          stack_reg[gi] <= (gi == 0) ? core_pc : stack_reg[(gi == 0) ? 0 : gi-1];
        end else if (pop && gi < STACK_N-1) begin
          stack_reg[gi] <= stack_reg[(gi < STACK_N-1) ? gi+1 : gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      depth_reg <= 3'h0;
    end else if (push && depth_reg != 3'(STACK_N)) begin
      depth_reg <= depth_reg + 3'h1;
    end else if (pop) begin
      depth_reg <= depth_reg - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Entry sequence and program counter loads
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= cipl_pkg::CIPL_ST_IDLE;
      cnt_reg   <= '0;
      vec_reg   <= 3'h0;
    end else begin
      unique case (state_reg)
        cipl_pkg::CIPL_ST_IDLE: begin
          if (accept) begin
            state_reg <= cipl_pkg::CIPL_ST_ENTRY;
            cnt_reg   <= RESP_LOAD;
            vec_reg   <= sel_vec;
          end
        end
        cipl_pkg::CIPL_ST_ENTRY: begin
          if (cnt_reg == '0) begin
            state_reg <= cipl_pkg::CIPL_ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - `CIPL_CNT_W'(1);
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pc_load_reg <= 1'b0;
      pc_addr_reg <= 12'h000;
    end else if (state_reg == cipl_pkg::CIPL_ST_ENTRY && cnt_reg == '0) begin
      pc_load_reg <= 1'b1;
      pc_addr_reg <= `CIPL_VEC_BASE + {8'h00, vec_reg, 1'b0};
    end else if (pop) begin
      pc_load_reg <= 1'b1;
      pc_addr_reg <= stack_reg[0];
    end else begin
      pc_load_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wake from low power
  // ----------------------------------------------------------------
  // Wait: any; stop: external and chosen
  assign any_src  = nmi_latch_reg | (gen_reg & |req[4:1]);
  assign stop_src = nmi_latch_reg | |ext_latch_reg |
                    (gen_reg & |(pflag_reg & pen_reg & STOP_WAKE_MASK));

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= (core_wait & any_src) | (core_stop & stop_src);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: no wait states, registered answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      gen_reg     <= 1'b0;
      conv_en_reg <= 1'b0;
      pen_reg     <= '0;
    end else if (wr_hit && paddr == `CIPL_ADDR_CTRL) begin
      gen_reg     <= pwdata[`CIPL_CTRL_GEN];
      conv_en_reg <= pwdata[`CIPL_CTRL_CONV_EN];
      pen_reg     <= pwdata[`CIPL_CTRL_PEN_LSB +: PERIPH_N];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~(paddr == `CIPL_ADDR_CTRL || paddr == `CIPL_ADDR_FLAGS ||
                               paddr == `CIPL_ADDR_STATUS);
      prdata_reg  <= 32'h0000_0000;
      if (setup && !pwrite) begin
        unique case (paddr)
          `CIPL_ADDR_CTRL:   prdata_reg <= 32'({pen_reg, 6'h00, conv_en_reg, gen_reg});
          `CIPL_ADDR_FLAGS:  prdata_reg <= 32'(pflag_reg);
          `CIPL_ADDR_STATUS: prdata_reg <= 32'({depth_reg, state_reg, nmi_latch_reg,
                                                ext_latch_reg, sel_reg, mode_reg});
          default:           prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign pc_load   = pc_load_reg;
  assign pc_addr   = pc_addr_reg;
  assign irq_mode  = mode_reg;
  assign flag_sel  = sel_reg;
  assign carry_out = carry_reg;
  assign zero_out  = zero_reg;
  assign wake      = wake_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int AST_RESP = `CIPL_RESP_MIN_CLKS;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_RESET_NMI_MODE: assert property (
    !$past(rst_b) |-> mode_reg == cipl_pkg::CIPL_MODE_NMI && sel_reg == cipl_pkg::CIPL_MODE_NMI)
    else $error("mode after reset not non-maskable");
  AST_NMI_NO_NEST: assert property (
    accept && sel_vec == 3'h0 |-> mode_reg != cipl_pkg::CIPL_MODE_NMI)
    else $error("non-maskable nested");
  AST_MASKABLE_BLOCK: assert property (
    accept && sel_vec != 3'h0 |-> gen_reg && mode_reg == cipl_pkg::CIPL_MODE_NORMAL)
    else $error("maskable taken while blocked");
  AST_PRIORITY: assert property (
    accept && !(req[0] && mode_reg != cipl_pkg::CIPL_MODE_NMI) && req[1] |-> sel_vec == 3'h1)
    else $error("priority order broken");
  AST_RESP_TIME: assert property (
    accept |-> ##AST_RESP pc_load_reg && pc_addr_reg[11:4] == `CIPL_VEC_BASE >> 4)
    else $error("vector load not at response time");
  AST_FLAG_STICKY: assert property (
    pflag_reg[0] && !pflag_clr[0] |=> pflag_reg[0])
    else $error("peripheral flag lost");
  AST_PUSH_PC: assert property (
    accept |=> stack_reg[0] == $past(core_pc))
    else $error("program counter not pushed");
  AST_NMI_CONTEXT: assert property (
    accept && sel_vec == 3'h0 |=> mode_reg == cipl_pkg::CIPL_MODE_NMI &&
                                  sel_reg == cipl_pkg::CIPL_MODE_NMI && $stable(cz_reg[2]))
    else $error("non-maskable context not entered");
  AST_NMI_LATCH_CLR: assert property (
    accept && sel_vec == 3'h0 && !fall[0] |=> !nmi_latch_reg)
    else $error("non-maskable latch not cleared");
  AST_LDI_NO_SWAP: assert property (
    accept && sel_vec != 3'h0 && core_ldi_ior_clr |=>
      mode_reg == cipl_pkg::CIPL_MODE_IRQ && sel_reg == $past(sel_reg))
    else $error("flag pair swapped during option clear");
  AST_RETURN_FROM_ISR_RESTORE: assert property (
    return_from_isr_ok && mode_reg == cipl_pkg::CIPL_MODE_IRQ |=>
      mode_reg == cipl_pkg::CIPL_MODE_NORMAL && sel_reg == $past(irq_prev_sel_reg))
    else $error("return did not restore context");
  AST_EOC_NO_STOP: assert property (
    core_stop && !core_wait && !stop_src |=> !wake_reg)
    else $error("stop woken by non-stop source");

  COV_NMI_OVER_IRQ: cover property (
    mode_reg == cipl_pkg::CIPL_MODE_IRQ && accept && sel_vec == 3'h0);
  COV_PERIPH_ENTRY: cover property (accept && sel_vec == 3'h4 ##[1:200] pc_load_reg);
  COV_RETURN_FROM_ISR_NORMAL: cover property (return_from_isr_ok && mode_reg == cipl_pkg::CIPL_MODE_IRQ);
  COV_STOP_WAKE: cover property (core_stop && stop_src ##1 wake_reg);

endmodule : cipl_ctrl

// >>> test/cipl_core_model.sv
// Core sequencer stand-in: instruction boundaries and program counter.
// Assumes mclk and rst_b are shared with the interrupt controller.
`timescale 1ns/10ps
module cipl_core_model (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_addr,
  output logic      [11:0] core_pc,
  output logic             core_instr_end
);
  logic [1:0] phase_reg;
  // ----------------------------------------------------------------
  // Four-cycle instructions, jump on every load
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign core_instr_end = (phase_reg == 2'h3);
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      core_pc <= 12'h100;
    end else if (pc_load) begin
      core_pc <= pc_addr;
    end
  end
endmodule : cipl_core_model

// >>> test/test_cipl_ctrl.sv
// Bench of the interrupt controller: APB master, pins, return pulses.
// Assumes the core model drives instruction ends and the program counter.
`timescale 1ns/10ps
`include "cipl_cfg.svh"
module test_cipl_ctrl;
  logic        mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic        nmi_pin_b = 1, core_return_from_isr = 0, lo = 0;
  logic        core_ldi = 0, core_wait = 0, core_stop = 0, flag_we = 0, carry_in = 0;
  logic        conv_done = 0, carry_out, zero_out, wake;
  logic [3:0]  port_pin = 4'hF, port_opt = 4'h0;
  logic [11:0] paddr = 0, core_pc, pc_addr;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, pc_load, core_instr_end, err;
  logic [1:0]  irq_mode, flag_sel, periph_evt = 0;
  int          err_count = 0, n_checks = 0, n;
  always #25 mclk = ~mclk;
  cipl_ctrl #(.VEC4_MASK(2'h2)) uut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .nmi_pin_b, .port_pin, .port_dir(4'h0),
    .pin_value_bits(4'h0), .port_opt, .periph_evt, .conv_done, .core_pc,
    .core_instr_end, .core_call(lo), .core_ret(lo), .core_return_from_isr, .core_ldi_ior_clr(core_ldi),
    .core_wait, .core_stop, .flag_we, .carry_in, .zero_in(lo), .pc_load,
    .pc_addr, .irq_mode, .flag_sel, .carry_out, .zero_out, .wake);
  cipl_core_model core (.mclk, .rst_b, .pc_load, .pc_addr, .core_pc, .core_instr_end);
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask : chk
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) begin err_count++; complete_run(); end
    @(posedge mclk);
  endtask : apb
  task automatic wait_load(input logic [11:0] exp);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pc_load !== 1'b1 && n < 300);
    if (n >= 300) begin err_count++; complete_run(); end
    chk(pc_addr === exp, "vector or return address");
  endtask : wait_load
  task automatic pulse_return_from_isr;
    core_return_from_isr <= 1'b1;
    @(posedge mclk);
    core_return_from_isr <= 1'b0;
  endtask : pulse_return_from_isr
  task automatic test_reset;
    chk(irq_mode === 2'h2 && flag_sel === 2'h2, "reset context");
    apb(1'b0, `CIPL_ADDR_STATUS, 32'h0);
    chk(rd[3:0] === 4'hA && err === 1'b0, "status context");
    apb(1'b1, 12'h00C, 32'h0000_0301);
    chk(err === 1'b1, "unmapped write refused");
    apb(1'b0, `CIPL_ADDR_CTRL, 32'h0);
    chk(rd === 32'h0, "control untouched");
    pulse_return_from_isr();
    @(posedge mclk);
    chk(irq_mode === 2'h0 && pc_load === 1'b0, "leave reset context");
    $display("test_reset done");
  endtask : test_reset
  task automatic test_gate;
    apb(1'b1, `CIPL_ADDR_CTRL, 32'h0000_0300);
    periph_evt <= 2'h3;
    @(posedge mclk);
    periph_evt <= 2'h0;
    repeat (40) @(posedge mclk);
    chk(irq_mode === 2'h0, "no entry without global enable");
    apb(1'b0, `CIPL_ADDR_FLAGS, 32'h0);
    chk(rd[1:0] === 2'h3, "flags held");
    nmi_pin_b <= 1'b0;
    wait_load(`CIPL_VEC_BASE);
    chk(irq_mode === 2'h2 && flag_sel === 2'h2, "nmi context");
    apb(1'b0, `CIPL_ADDR_STATUS, 32'h0);
    chk(rd[6] === 1'b0 && rd[10:8] === 3'h1, "latch cleared, pushed");
    nmi_pin_b <= 1'b1;
    pulse_return_from_isr();
    wait_load(12'h100);
    chk(irq_mode === 2'h0 && flag_sel === 2'h0, "main context back");
    $display("test_gate done");
  endtask : test_gate
  task automatic test_prio;
    apb(1'b1, `CIPL_ADDR_CTRL, 32'h0000_0301);
    wait_load(12'hFF6);
    chk(n >= 78 && n <= 143, "response time");
    chk(irq_mode === 2'h1 && flag_sel === 2'h1, "irq context");
    apb(1'b1, `CIPL_ADDR_FLAGS, 32'h1);
    nmi_pin_b <= 1'b0;
    wait_load(`CIPL_VEC_BASE);
    nmi_pin_b <= 1'b1;
    pulse_return_from_isr();
    wait_load(12'hFF6);
    chk(irq_mode === 2'h1 && flag_sel === 2'h1, "irq context back");
    pulse_return_from_isr();
    wait_load(12'h100);
    wait_load(12'hFF8);
    apb(1'b1, `CIPL_ADDR_FLAGS, 32'h2);
    $display("test_prio done");
  endtask : test_prio
  task automatic test_misc;
    pulse_return_from_isr();
    wait_load(12'h100);
    flag_we <= 1'b1; carry_in <= 1'b1;
    @(posedge mclk);
    flag_we <= 1'b0; carry_in <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(carry_out === 1'b1 && zero_out === 1'b0, "main flags written");
    port_pin[0] <= 1'b0;
    repeat (10) @(posedge mclk);
    apb(1'b0, `CIPL_ADDR_STATUS, 32'h0);
    chk(rd[5:4] === 2'h0 && irq_mode === 2'h0, "unconfigured port event");
    port_pin[0] <= 1'b1; port_opt[0] <= 1'b1;
    repeat (6) @(posedge mclk);
    port_pin[0] <= 1'b0;
    wait_load(12'hFF2);
    chk(flag_sel === 2'h1 && carry_out === 1'b0, "irq flag pair");
    port_pin[0] <= 1'b1;
    pulse_return_from_isr();
    wait_load(12'h100);
    chk(flag_sel === 2'h0 && carry_out === 1'b1, "main flags kept");
    core_ldi <= 1'b1; periph_evt <= 2'h1;
    @(posedge mclk);
    periph_evt <= 2'h0;
    wait_load(12'hFF6);
    core_ldi <= 1'b0;
    chk(irq_mode === 2'h1 && flag_sel === 2'h0, "option clear keeps pair");
    apb(1'b1, `CIPL_ADDR_FLAGS, 32'h1);
    apb(1'b1, `CIPL_ADDR_CTRL, 32'h0000_0303);
    conv_done <= 1'b1; core_stop <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(wake === 1'b0, "conversion woke stop");
    core_stop <= 1'b0; core_wait <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(wake === 1'b1, "conversion did not wake wait");
    conv_done <= 1'b0; core_wait <= 1'b0; core_stop <= 1'b1; port_pin[0] <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(wake === 1'b1 && irq_mode === 2'h1, "external stop wake");
    core_stop <= 1'b0;
    pulse_return_from_isr();
    wait_load(12'h100);
    wait_load(12'hFF2);
    $display("test_misc done");
  endtask : test_misc
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    test_reset();
    test_gate();
    test_prio();
    test_misc();
    complete_run();
  end
endmodule : test_cipl_ctrl
